// >>> pkg/nctad_pkg.sv
// Package of constants, opcodes and carriers for the nibble core datapath
package nctad_pkg;
   localparam int unsigned NCTAD_PC_W = 14;
   localparam int unsigned NCTAD_PAGE_W = 7;
   localparam int unsigned NCTAD_RAM_AW = 10;
   localparam int unsigned NCTAD_STACK_DEPTH = 8;
   localparam int unsigned NCTAD_SIDX_W = 3;
   localparam int unsigned NCTAD_ROM_W = 10;
   localparam int unsigned NCTAD_SKIPPED_CYCLES = 1;
   localparam logic [3:0] NCTAD_NIB_ZERO = 4'h0;
   localparam logic [3:0] NCTAD_NIB_ONE = 4'h1;
   localparam logic [13:0] NCTAD_PC_RESET = 14'h0000;
   localparam logic [2:0] NCTAD_SIDX_RESET = 3'h7;
   localparam logic [2:0] NCTAD_SIDX_ONE = 3'h1;
   localparam logic [13:0] NCTAD_PC_ONE = 14'h0001;

   typedef enum logic [5:0] {
      NCTAD_OP_NOP = 6'h00,
      NCTAD_OP_READ_B_TO_ACC = 6'h01,
      NCTAD_OP_COPY_ACC_INTO_B = 6'h02,
      NCTAD_OP_READ_Y_TO_ACC = 6'h03,
      NCTAD_OP_WRITE_Y_FROM_ACC = 6'h04,
      NCTAD_OP_COPY_ACC_TO_TABLE_PAGE = 6'h05,
      NCTAD_OP_READ_TABLE_PAGE_TO_ACC = 6'h06,
      NCTAD_OP_READ_Z_TO_ACC = 6'h07,
      NCTAD_OP_READ_X_TO_ACC = 6'h08,
      NCTAD_OP_READ_STACK_INDEX_TO_ACC = 6'h09,
      NCTAD_OP_LOAD_X_Y_FIELDS = 6'h0a,
      NCTAD_OP_LOAD_Z_FIELD = 6'h0b,
      NCTAD_OP_INCREMENT_Y_POINTER = 6'h0c,
      NCTAD_OP_DECREMENT_Y_POINTER = 6'h0d,
      NCTAD_OP_LOAD_ACC_FROM_RAM = 6'h0e,
      NCTAD_OP_STORE_ACC_TO_RAM = 6'h0f,
      NCTAD_OP_SWAP_ACC_RAM = 6'h10,
      NCTAD_OP_SWAP_ACC_RAM_DEC_Y = 6'h11,
      NCTAD_OP_SWAP_ACC_RAM_INC_Y = 6'h12,
      NCTAD_OP_LOAD_ACC_IMM = 6'h13,
      NCTAD_OP_ROM_TABLE_LOOKUP = 6'h14,
      NCTAD_OP_ADD_MEM_TO_ACC = 6'h15,
      NCTAD_OP_ADD_MEM_WITH_CARRY = 6'h16,
      NCTAD_OP_ADD_IMM = 6'h17,
      NCTAD_OP_AND_MEM = 6'h18,
      NCTAD_OP_OR_MEM = 6'h19,
      NCTAD_OP_SET_CARRY = 6'h1a,
      NCTAD_OP_RESET_CARRY = 6'h1b,
      NCTAD_OP_SKIP_IF_CARRY_CLEAR = 6'h1c,
      NCTAD_OP_COMPLEMENT_ACC = 6'h1d,
      NCTAD_OP_ROTATE_RIGHT_THRU_CARRY = 6'h1e,
      NCTAD_OP_RETURN_FROM_CALL = 6'h1f,
      NCTAD_OP_RETURN_WITH_SKIP = 6'h20
   } nctad_op_t;

   typedef enum logic [1:0] {
      NCTAD_ST_IDLE = 2'b00,
      NCTAD_ST_TABLE_READ = 2'b01,
      NCTAD_ST_TABLE_POP = 2'b10
   } nctad_state_t;

   // Instruction word handed in by the sequencer
   typedef struct packed {
      nctad_op_t op;
      logic [3:0] imm_a;
      logic [3:0] imm_b;
      logic [5:0] page;
   } nctad_instr_t;

   // RAM nibble request
   typedef struct packed {
      logic [9:0] addr;
      logic we;
      logic [3:0] wdata;
   } nctad_ram_req_t;
endpackage

// >>> rtl/nctad_datapath.sv
// Execution datapath of the nibble core: registers, skip, transfer and ALU
`timescale 1ns/100ps
module nctad_datapath (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_instr_valid,
   input wire nctad_pkg::nctad_instr_t i_instr,
   input wire logic [3:0] i_ram_rdata,
   input wire logic [9:0] i_rom_rdata,
   input wire logic i_skip_request,
   input wire logic i_push,
   input wire logic i_jump,
   input wire logic [13:0] i_jump_target,
   output logic o_busy,
   output logic o_skip_pending,
   output nctad_pkg::nctad_ram_req_t o_ram_req,
   output logic [13:0] o_rom_addr,
   output logic [13:0] o_pc,
   output logic [9:0] o_ram_pointer,
   output logic [3:0] o_acc,
   output logic [3:0] o_b_reg,
   output logic o_carry_flag,
   output logic [2:0] o_table_page_register,
   output logic [2:0] o_return_stack_index
);
   logic [6:0] counter_high_part_q, counter_high_part_d;
   logic [6:0] counter_low_part_q, counter_low_part_d;
   logic [13:0] return_stack_q [nctad_pkg::NCTAD_STACK_DEPTH];
   logic [13:0] stack_wdata;
   logic stack_we;
   logic [2:0] return_stack_index_q, return_stack_index_d;
   logic [3:0] acc_q, acc_d;
   logic [3:0] b_q, b_d;
   logic [3:0] x_q, x_d;
   logic [3:0] y_q, y_d;
   logic [1:0] z_q, z_d;
   logic [2:0] table_page_register_q, table_page_register_d;
   logic carry_flag_q, carry_flag_d;
   logic skip_q, skip_d;
   logic [9:0] ram_pointer;
   logic [13:0] pc;
   logic [4:0] sum;
   logic ram_we;
   logic [3:0] ram_wdata;
   nctad_pkg::nctad_state_t state_q, state_d;
   nctad_pkg::nctad_op_t op;

   // Four-bit add with carry in, five-bit result
   function automatic logic [4:0] nib_add(input logic [3:0] a,
      input logic [3:0] b, input logic c);
      nib_add = {1'b0, a} + {1'b0, b} + {4'h0, c};
   endfunction

   // X updated by immediate j after a RAM transfer
   function automatic logic [3:0] x_xor(input logic [3:0] x,
      input logic [3:0] j);
      x_xor = x ^ j;
   endfunction

   // Program counter step to the next instruction
   function automatic logic [13:0] pc_inc(input logic [13:0] p);
      pc_inc = p + nctad_pkg::NCTAD_PC_ONE;
   endfunction

   // Y pointer step, wrapping modulo sixteen
   function automatic logic [3:0] y_step(input logic [3:0] y,
      input logic up);
      y_step = up ? y + nctad_pkg::NCTAD_NIB_ONE :
         y - nctad_pkg::NCTAD_NIB_ONE;
   endfunction

   // Stack index step, wrapping in three bits
   function automatic logic [2:0] idx_step(input logic [2:0] idx,
      input logic up);
      idx_step = up ? idx + nctad_pkg::NCTAD_SIDX_ONE :
         idx - nctad_pkg::NCTAD_SIDX_ONE;
   endfunction

   assign op = i_instr.op;
   assign ram_pointer = {z_q, x_q, y_q};
   assign pc = {counter_high_part_q, counter_low_part_q};

   always_comb begin
      counter_high_part_d = counter_high_part_q;
      counter_low_part_d = counter_low_part_q;
      return_stack_index_d = return_stack_index_q;
      stack_we = 1'b0;
      stack_wdata = pc;
      acc_d = acc_q;
      b_d = b_q;
      x_d = x_q;
      y_d = y_q;
      z_d = z_q;
      table_page_register_d = table_page_register_q;
      carry_flag_d = carry_flag_q;
      skip_d = skip_q;
      state_d = state_q;
      ram_we = 1'b0;
      ram_wdata = acc_q;
      sum = 5'h00;
      case (state_q)
         nctad_pkg::NCTAD_ST_IDLE: begin
            if (i_instr_valid) begin
               // Step past the instruction, skipped or not; jumps, lookups and returns override the PC below
               {counter_high_part_d, counter_low_part_d} =
                  pc_inc(pc);
               skip_d = 1'b0;
               if (skip_q) begin
                  // Voided instruction; lookups and returns take one cycle
                  state_d = nctad_pkg::NCTAD_ST_IDLE;
               end else begin
                  if (i_push) begin
                     return_stack_index_d =
                        idx_step(return_stack_index_q, 1'b1);
                     stack_we = 1'b1;
                     stack_wdata = pc_inc(pc);
                  end
                  if (i_jump) begin
                     {counter_high_part_d, counter_low_part_d} =
                        i_jump_target;
                  end
                  skip_d = i_skip_request;
                  case (op)
                     nctad_pkg::NCTAD_OP_READ_B_TO_ACC: begin
                        acc_d = b_q;
                     end
                     nctad_pkg::NCTAD_OP_COPY_ACC_INTO_B: begin
                        b_d = acc_q;
                     end
                     nctad_pkg::NCTAD_OP_READ_Y_TO_ACC: begin
                        acc_d = y_q;
                     end
                     nctad_pkg::NCTAD_OP_WRITE_Y_FROM_ACC: begin
                        y_d = acc_q;
                     end
                     nctad_pkg::NCTAD_OP_COPY_ACC_TO_TABLE_PAGE: begin
                        table_page_register_d = acc_q[2:0];
                     end
                     nctad_pkg::NCTAD_OP_READ_TABLE_PAGE_TO_ACC: begin
                        acc_d = {1'b0, table_page_register_q};
                     end
                     nctad_pkg::NCTAD_OP_READ_Z_TO_ACC: begin
                        acc_d = {2'b00, z_q};
                     end
                     nctad_pkg::NCTAD_OP_READ_X_TO_ACC: begin
                        acc_d = x_q;
                     end
                     nctad_pkg::NCTAD_OP_READ_STACK_INDEX_TO_ACC: begin
                        acc_d = {1'b0, return_stack_index_q};
                     end
                     nctad_pkg::NCTAD_OP_LOAD_X_Y_FIELDS: begin
                        x_d = i_instr.imm_a;
                        y_d = i_instr.imm_b;
                     end
                     nctad_pkg::NCTAD_OP_LOAD_Z_FIELD: begin
                        z_d = i_instr.imm_a[1:0];
                     end
                     nctad_pkg::NCTAD_OP_INCREMENT_Y_POINTER: begin
                        y_d = y_step(y_q, 1'b1);
                     end
                     nctad_pkg::NCTAD_OP_DECREMENT_Y_POINTER: begin
                        y_d = y_step(y_q, 1'b0);
                     end
                     nctad_pkg::NCTAD_OP_LOAD_ACC_FROM_RAM: begin
                        acc_d = i_ram_rdata;
                        x_d = x_xor(x_q, i_instr.imm_a);
                     end
                     nctad_pkg::NCTAD_OP_STORE_ACC_TO_RAM: begin
                        ram_we = 1'b1;
                        x_d = x_xor(x_q, i_instr.imm_a);
                     end
                     nctad_pkg::NCTAD_OP_SWAP_ACC_RAM: begin
                        ram_we = 1'b1;
                        acc_d = i_ram_rdata;
                        x_d = x_xor(x_q, i_instr.imm_a);
                     end
                     nctad_pkg::NCTAD_OP_SWAP_ACC_RAM_DEC_Y: begin
                        ram_we = 1'b1;
                        acc_d = i_ram_rdata;
                        x_d = x_xor(x_q, i_instr.imm_a);
                        y_d = y_step(y_q, 1'b0);
                     end
                     nctad_pkg::NCTAD_OP_SWAP_ACC_RAM_INC_Y: begin
                        ram_we = 1'b1;
                        acc_d = i_ram_rdata;
                        x_d = x_xor(x_q, i_instr.imm_a);
                        y_d = y_step(y_q, 1'b1);
                     end
                     nctad_pkg::NCTAD_OP_LOAD_ACC_IMM: begin
                        acc_d = i_instr.imm_a;
                     end
                     nctad_pkg::NCTAD_OP_ROM_TABLE_LOOKUP: begin
                        // Push return address, jump into the table
                        return_stack_index_d =
                           idx_step(return_stack_index_q, 1'b1);
                        stack_we = 1'b1;
                        stack_wdata = pc_inc(pc);
                        counter_high_part_d = {1'b0, i_instr.page};
                        counter_low_part_d = {table_page_register_q,
                           acc_q};
                        state_d = nctad_pkg::NCTAD_ST_TABLE_READ;
                     end
                     nctad_pkg::NCTAD_OP_ADD_MEM_TO_ACC: begin
                        sum = nib_add(acc_q, i_ram_rdata, 1'b0);
                        acc_d = sum[3:0];
                     end
                     nctad_pkg::NCTAD_OP_ADD_MEM_WITH_CARRY: begin
                        sum = nib_add(acc_q, i_ram_rdata, carry_flag_q);
                        acc_d = sum[3:0];
                        carry_flag_d = sum[4];
                     end
                     nctad_pkg::NCTAD_OP_ADD_IMM: begin
                        sum = nib_add(acc_q, i_instr.imm_a, 1'b0);
                        acc_d = sum[3:0];
                     end
                     nctad_pkg::NCTAD_OP_AND_MEM: begin
                        acc_d = acc_q & i_ram_rdata;
                     end
                     nctad_pkg::NCTAD_OP_OR_MEM: begin
                        acc_d = acc_q | i_ram_rdata;
                     end
                     nctad_pkg::NCTAD_OP_SET_CARRY: begin
                        carry_flag_d = 1'b1;
                     end
                     nctad_pkg::NCTAD_OP_RESET_CARRY: begin
                        carry_flag_d = 1'b0;
                     end
                     nctad_pkg::NCTAD_OP_SKIP_IF_CARRY_CLEAR: begin
                        skip_d = i_skip_request | ~carry_flag_q;
                     end
                     nctad_pkg::NCTAD_OP_COMPLEMENT_ACC: begin
                        acc_d = ~acc_q;
                     end
                     nctad_pkg::NCTAD_OP_ROTATE_RIGHT_THRU_CARRY: begin
                        acc_d = {carry_flag_q, acc_q[3:1]};
                        carry_flag_d = acc_q[0];
                     end
                     nctad_pkg::NCTAD_OP_RETURN_FROM_CALL,
                     nctad_pkg::NCTAD_OP_RETURN_WITH_SKIP: begin
                        {counter_high_part_d, counter_low_part_d} =
                           return_stack_q[return_stack_index_q];
                        return_stack_index_d =
                           idx_step(return_stack_index_q, 1'b0);
                        skip_d = i_skip_request |
                           (op == nctad_pkg::NCTAD_OP_RETURN_WITH_SKIP);
                     end
                     default: begin
                        acc_d = acc_q;
                     end
                  endcase
               end
            end
         end
         nctad_pkg::NCTAD_ST_TABLE_READ: begin
            // ROM word at the table address lands in registers
            table_page_register_d = {table_page_register_q[2],
               i_rom_rdata[9:8]};
            b_d = i_rom_rdata[7:4];
            acc_d = i_rom_rdata[3:0];
            state_d = nctad_pkg::NCTAD_ST_TABLE_POP;
         end
         nctad_pkg::NCTAD_ST_TABLE_POP: begin
            {counter_high_part_d, counter_low_part_d} =
               return_stack_q[return_stack_index_q];
            return_stack_index_d =
               idx_step(return_stack_index_q, 1'b0);
            state_d = nctad_pkg::NCTAD_ST_IDLE;
         end
         default: begin
            state_d = nctad_pkg::NCTAD_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         counter_high_part_q <= nctad_pkg::NCTAD_PC_RESET[13:7];
         counter_low_part_q <= nctad_pkg::NCTAD_PC_RESET[6:0];
         return_stack_index_q <= nctad_pkg::NCTAD_SIDX_RESET;
         acc_q <= nctad_pkg::NCTAD_NIB_ZERO;
         b_q <= nctad_pkg::NCTAD_NIB_ZERO;
         x_q <= nctad_pkg::NCTAD_NIB_ZERO;
         y_q <= nctad_pkg::NCTAD_NIB_ZERO;
         z_q <= 2'b00;
         table_page_register_q <= 3'h0;
         carry_flag_q <= 1'b0;
         skip_q <= 1'b0;
         state_q <= nctad_pkg::NCTAD_ST_IDLE;
      end else begin
         counter_high_part_q <= counter_high_part_d;
         counter_low_part_q <= counter_low_part_d;
         return_stack_index_q <= return_stack_index_d;
         acc_q <= acc_d;
         b_q <= b_d;
         x_q <= x_d;
         y_q <= y_d;
         z_q <= z_d;
         table_page_register_q <= table_page_register_d;
         carry_flag_q <= carry_flag_d;
         skip_q <= skip_d;
         state_q <= state_d;
      end
   end

   // Stack storage, written at the incremented index
   always_ff @(posedge i_clock) begin
      if (stack_we) begin
         return_stack_q[return_stack_index_d] <= stack_wdata;
      end
   end

   assign o_busy = (state_q != nctad_pkg::NCTAD_ST_IDLE);
   assign o_skip_pending = skip_q;
   assign o_ram_req.addr = ram_pointer;
   assign o_ram_req.we = ram_we;
   assign o_ram_req.wdata = ram_wdata;
   assign o_rom_addr = pc;
   assign o_pc = pc;
   assign o_ram_pointer = ram_pointer;
   assign o_acc = acc_q;
   assign o_b_reg = b_q;
   assign o_carry_flag = carry_flag_q;
   assign o_table_page_register = table_page_register_q;
   assign o_return_stack_index = return_stack_index_q;
endmodule // nctad_datapath

// >>> dv/nctad_datapath_checker.sv
// Port checker of the nibble core datapath
`timescale 1ns/100ps
module nctad_datapath_checker (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_instr_valid,
   input wire nctad_pkg::nctad_instr_t i_instr,
   input wire logic o_busy,
   input wire logic o_skip_pending,
   input wire nctad_pkg::nctad_ram_req_t o_ram_req,
   input wire logic [13:0] o_pc,
   input wire logic [9:0] o_ram_pointer,
   input wire logic [3:0] o_acc,
   input wire logic o_carry_flag,
   input wire logic [2:0] o_return_stack_index
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_run(logic [5:0] k);
      i_instr_valid && !o_busy && !o_skip_pending && i_instr.op == k;
   endsequence
   sequence s_void;
      i_instr_valid && !o_busy && o_skip_pending;
   endsequence
   a_ptr_to_ram: assert property (o_ram_req.addr == o_ram_pointer)
      else $error("RAM address differs from pointer");
   a_store_acc: assert property (o_ram_req.we |->
      o_ram_req.wdata == o_acc && i_instr_valid && !o_skip_pending)
      else $error("RAM write data differs from acc");
   a_skip_voids: assert property (s_void |=> o_acc == $past(o_acc)
      && o_carry_flag == $past(o_carry_flag)
      && o_pc == $past(o_pc) + 14'h0001)
      else $error("Voided instruction changed state");
   a_void_short: assert property (s_void ##0
      i_instr.op == nctad_pkg::NCTAD_OP_ROM_TABLE_LOOKUP |=> !o_busy)
      else $error("Voided lookup took extra cycles");
   a_lookup_busy: assert property (
      s_run(nctad_pkg::NCTAD_OP_ROM_TABLE_LOOKUP) |=> o_busy [*2] ##1 !o_busy)
      else $error("Lookup busy span wrong");
   a_lookup_ret: assert property (
      s_run(nctad_pkg::NCTAD_OP_ROM_TABLE_LOOKUP) |-> ##3
      o_pc == $past(o_pc, 3) + 14'h0001
      && o_return_stack_index == $past(o_return_stack_index, 3))
      else $error("Lookup did not restore PC and index");
   a_carry_set: assert property (
      s_run(nctad_pkg::NCTAD_OP_SET_CARRY) |=> o_carry_flag)
      else $error("Carry not set");
   a_carry_clear: assert property (
      s_run(nctad_pkg::NCTAD_OP_RESET_CARRY) |=> !o_carry_flag)
      else $error("Carry not cleared");
   a_test_skips: assert property (
      s_run(nctad_pkg::NCTAD_OP_SKIP_IF_CARRY_CLEAR) ##0 !o_carry_flag
      |=> o_skip_pending)
      else $error("Carry test did not skip");
   a_compl_acc: assert property (
      s_run(nctad_pkg::NCTAD_OP_COMPLEMENT_ACC) |=> o_acc == ~$past(o_acc))
      else $error("Complement wrong");
   a_rotate_chain: assert property (
      s_run(nctad_pkg::NCTAD_OP_ROTATE_RIGHT_THRU_CARRY) |=>
      {o_acc, o_carry_flag} == {$past(o_carry_flag), $past(o_acc)})
      else $error("Rotate through carry wrong");
   a_z_zero_fill: assert property (
      s_run(nctad_pkg::NCTAD_OP_READ_Z_TO_ACC) |=> o_acc[3:2] == 2'b00)
      else $error("Z read left upper bits set");
   a_lxy_pointer: assert property (
      s_run(nctad_pkg::NCTAD_OP_LOAD_X_Y_FIELDS) |=>
      o_ram_pointer[7:0] == $past({i_instr.imm_a, i_instr.imm_b}))
      else $error("Pointer after X and Y load wrong");
endmodule // nctad_datapath_checker

// >>> dv/nctad_mem_model.sv
// Sequencer-side RAM and ROM model
`timescale 1ns/100ps
module nctad_mem_model (
   input wire logic i_clock,
   input wire nctad_pkg::nctad_ram_req_t i_ram_req,
   input wire logic [13:0] i_rom_addr,
   output logic [3:0] o_ram_rdata,
   output logic [9:0] o_rom_rdata
);
   logic [3:0] mem_q [0:1023];
   initial begin
      for (int k = 0; k < 1024; k++) begin
         mem_q[k] = 4'h0;
      end
   end
   assign o_ram_rdata = mem_q[i_ram_req.addr];
   assign o_rom_rdata = i_rom_addr[9:0] ^ 10'h2c3;
   always @(posedge i_clock) begin
      if (i_ram_req.we === 1'b1) begin
         mem_q[i_ram_req.addr] <= i_ram_req.wdata;
      end
   end
endmodule // nctad_mem_model

// >>> dv/nctad_datapath_bench.sv
// Self-checking bench of the nibble core datapath
`timescale 1ns/100ps
module nctad_datapath_bench;
   typedef struct packed {
      logic [5:0] op;
      logic [3:0] a;
      logic [3:0] b;
      logic [3:0] acc;
      logic [9:0] ptr;
      logic cy;
   } nctad_row_t;
   localparam int N_ROWS = 39;
   localparam nctad_row_t ROWS [0:N_ROWS-1] = '{
      '{6'h0a, 4'hf, 4'h3, 4'h0, 10'h0f3, 1'b0},
      '{6'h0b, 4'h3, 4'h0, 4'h0, 10'h3f3, 1'b0},
      '{6'h13, 4'h9, 4'h0, 4'h9, 10'h3f3, 1'b0},
      '{6'h0f, 4'h5, 4'h0, 4'h9, 10'h3a3, 1'b0},
      '{6'h17, 4'hc, 4'h0, 4'h5, 10'h3a3, 1'b0},
      '{6'h0f, 4'h5, 4'h0, 4'h5, 10'h3f3, 1'b0},
      '{6'h15, 4'h0, 4'h0, 4'he, 10'h3f3, 1'b0},
      '{6'h1a, 4'h0, 4'h0, 4'he, 10'h3f3, 1'b1},
      '{6'h16, 4'h0, 4'h0, 4'h8, 10'h3f3, 1'b1},
      '{6'h1b, 4'h0, 4'h0, 4'h8, 10'h3f3, 1'b0},
      '{6'h1d, 4'h0, 4'h0, 4'h7, 10'h3f3, 1'b0},
      '{6'h19, 4'h0, 4'h0, 4'hf, 10'h3f3, 1'b0},
      '{6'h18, 4'h0, 4'h0, 4'h9, 10'h3f3, 1'b0},
      '{6'h1a, 4'h0, 4'h0, 4'h9, 10'h3f3, 1'b1},
      '{6'h1e, 4'h0, 4'h0, 4'hc, 10'h3f3, 1'b1},
      '{6'h1e, 4'h0, 4'h0, 4'he, 10'h3f3, 1'b0},
      '{6'h10, 4'h0, 4'h0, 4'h9, 10'h3f3, 1'b0},
      '{6'h11, 4'h5, 4'h0, 4'he, 10'h3a2, 1'b0},
      '{6'h12, 4'h5, 4'h0, 4'h0, 10'h3f3, 1'b0},
      '{6'h0e, 4'h5, 4'h0, 4'h9, 10'h3a3, 1'b0},
      '{6'h0e, 4'h0, 4'h0, 4'h5, 10'h3a3, 1'b0},
      '{6'h02, 4'h0, 4'h0, 4'h5, 10'h3a3, 1'b0},
      '{6'h13, 4'h0, 4'h0, 4'h0, 10'h3a3, 1'b0},
      '{6'h01, 4'h0, 4'h0, 4'h5, 10'h3a3, 1'b0},
      '{6'h04, 4'h0, 4'h0, 4'h5, 10'h3a5, 1'b0},
      '{6'h0c, 4'h0, 4'h0, 4'h5, 10'h3a6, 1'b0},
      '{6'h0d, 4'h0, 4'h0, 4'h5, 10'h3a5, 1'b0},
      '{6'h0a, 4'h0, 4'h0, 4'h5, 10'h300, 1'b0},
      '{6'h0d, 4'h0, 4'h0, 4'h5, 10'h30f, 1'b0},
      '{6'h0c, 4'h0, 4'h0, 4'h5, 10'h300, 1'b0},
      '{6'h13, 4'hd, 4'h0, 4'hd, 10'h300, 1'b0},
      '{6'h05, 4'h0, 4'h0, 4'hd, 10'h300, 1'b0},
      '{6'h13, 4'hf, 4'h0, 4'hf, 10'h300, 1'b0},
      '{6'h06, 4'h0, 4'h0, 4'h5, 10'h300, 1'b0},
      '{6'h07, 4'h0, 4'h0, 4'h3, 10'h300, 1'b0},
      '{6'h0a, 4'hc, 4'h4, 4'h3, 10'h3c4, 1'b0},
      '{6'h08, 4'h0, 4'h0, 4'hc, 10'h3c4, 1'b0},
      '{6'h03, 4'h0, 4'h0, 4'h4, 10'h3c4, 1'b0},
      '{6'h09, 4'h0, 4'h0, 4'h7, 10'h3c4, 1'b0}
   };
   logic i_clock, i_sys_rst, i_instr_valid, i_skip_request, i_push, i_jump;
   nctad_pkg::nctad_instr_t i_instr;
   logic [3:0] i_ram_rdata;
   logic [9:0] i_rom_rdata;
   logic [13:0] i_jump_target, o_rom_addr, o_pc, pc_mark;
   logic o_busy, o_skip_pending, o_carry_flag;
   nctad_pkg::nctad_ram_req_t o_ram_req;
   logic [9:0] o_ram_pointer, word;
   logic [3:0] o_acc, o_b_reg;
   logic [2:0] o_table_page_register, o_return_stack_index;
   int num_errors = 0;
   int tests_run = 0;
   int k;
   logic [3:0] imm_y = 4'h0;
   nctad_datapath u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_ram_rdata(i_ram_rdata), .i_rom_rdata(i_rom_rdata),
      .i_skip_request(i_skip_request), .i_push(i_push), .i_jump(i_jump),
      .i_jump_target(i_jump_target), .o_busy(o_busy),
      .o_skip_pending(o_skip_pending), .o_ram_req(o_ram_req),
      .o_rom_addr(o_rom_addr), .o_pc(o_pc), .o_ram_pointer(o_ram_pointer),
      .o_acc(o_acc), .o_b_reg(o_b_reg), .o_carry_flag(o_carry_flag),
      .o_table_page_register(o_table_page_register),
      .o_return_stack_index(o_return_stack_index));
   nctad_mem_model u_mem (.i_clock(i_clock), .i_ram_req(o_ram_req),
      .i_rom_addr(o_rom_addr), .o_ram_rdata(i_ram_rdata),
      .o_rom_rdata(i_rom_rdata));
   task automatic chk(input logic [13:0] got, input logic [13:0] exp,
         input string what);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t ns: %s mismatch", $time, what);
      end
   endtask
   task automatic issue(input logic [5:0] op, input logic [3:0] a,
         input logic [5:0] pg);
      i_instr = '{nctad_pkg::nctad_op_t'(op), a, imm_y, pg};
      i_instr_valid = 1'b1;
      @(posedge i_clock);
      #1;
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   initial begin
      repeat (2000) @(posedge i_clock);
      num_errors++;
      $display("[ERR] %0t ns: watchdog expired", $time);
      give_verdict();
   end
   initial begin
      i_sys_rst = 1'b1;
      i_instr_valid = 1'b0;
      i_skip_request = 1'b0;
      i_push = 1'b0;
      i_jump = 1'b0;
      i_jump_target = 14'h0000;
      i_instr = '0;
      repeat (10) @(posedge i_clock);
      #1;
      i_sys_rst = 1'b0;
      chk(o_pc, 14'h0000, "reset pc");
      chk(14'(o_return_stack_index), 14'h0007, "reset index");
      chk(14'({o_acc, o_busy, o_skip_pending, o_carry_flag}), 14'h0000,
         "reset state");
      $display("Test reset done");
      for (int r = 0; r < N_ROWS; r++) begin
         imm_y = ROWS[r].b;
         issue(ROWS[r].op, ROWS[r].a, 6'h00);
         chk(14'(o_acc), 14'(ROWS[r].acc), "acc");
         chk(14'(o_ram_pointer), 14'(ROWS[r].ptr), "pointer");
         chk(14'(o_carry_flag), 14'(ROWS[r].cy), "carry");
      end
      $display("Test table done");
      issue(6'h1c, 4'h0, 6'h00);
      chk(14'(o_skip_pending), 14'h0001, "skip flag");
      issue(6'h17, 4'h1, 6'h00);
      chk(14'(o_acc), 14'h0007, "voided add");
      issue(6'h1c, 4'h0, 6'h00);
      pc_mark = o_pc;
      issue(6'h14, 4'h0, 6'h2a);
      chk(14'(o_busy), 14'h0000, "voided lookup");
      chk(o_pc, pc_mark + 14'h0001, "voided pc");
      i_skip_request = 1'b1;
      issue(6'h00, 4'h0, 6'h00);
      i_skip_request = 1'b0;
      issue(6'h1f, 4'h0, 6'h00);
      chk(14'(o_busy), 14'h0000, "voided return");
      chk(14'(o_return_stack_index), 14'h0007, "voided pop");
      $display("Test skip done");
      issue(6'h13, 4'h6, 6'h00);
      issue(6'h05, 4'h0, 6'h00);
      issue(6'h13, 4'ha, 6'h00);
      i_instr = '0;
      i_jump = 1'b1;
      i_jump_target = 14'h2abc;
      @(posedge i_clock);
      #1;
      i_jump = 1'b0;
      chk(o_pc, 14'h2abc, "jump");
      issue(6'h14, 4'h0, 6'h2a);
      i_instr_valid = 1'b0;
      chk(o_rom_addr, 14'h156a, "table address");
      chk(14'(o_return_stack_index), 14'h0000, "push index");
      k = 0;
      while (o_busy !== 1'b0 && k < 6) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      word = 10'h16a ^ 10'h2c3;
      chk(14'(k), 14'h0002, "busy span");
      chk(14'(o_acc), 14'(word[3:0]), "table acc");
      chk(14'(o_b_reg), 14'(word[7:4]), "table b");
      chk(14'(o_table_page_register), 14'({1'b1, word[9:8]}),
         "table page");
      chk(o_pc, 14'h2abd, "popped pc");
      chk(14'(o_return_stack_index), 14'h0007, "pop index");
      $display("Test lookup done");
      pc_mark = o_pc;
      i_push = 1'b1;
      i_jump = 1'b1;
      issue(6'h00, 4'h0, 6'h00);
      i_push = 1'b0;
      i_jump = 1'b0;
      chk(14'(o_return_stack_index), 14'h0000, "call index");
      issue(6'h20, 4'h0, 6'h00);
      chk(o_pc, pc_mark + 14'h0001, "return pc");
      chk(14'(o_return_stack_index), 14'h0007, "return index");
      chk(14'(o_skip_pending), 14'h0001, "return skip");
      issue(6'h13, 4'h3, 6'h00);
      i_instr_valid = 1'b0;
      chk(14'(o_acc), 14'(word[3:0]), "skipped load");
      $display("Test return done");
      give_verdict();
   end
endmodule // nctad_datapath_bench
bind nctad_datapath nctad_datapath_checker u_chk (.i_clock(i_clock),
   .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid),
   .i_instr(i_instr), .o_busy(o_busy), .o_skip_pending(o_skip_pending),
   .o_ram_req(o_ram_req), .o_pc(o_pc), .o_ram_pointer(o_ram_pointer),
   .o_acc(o_acc), .o_carry_flag(o_carry_flag),
   .o_return_stack_index(o_return_stack_index));
